// ### shared/rx_gain_pkg.sv
// Package: register map, field positions, reset values, timing for rx_gain_control.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package rx_gain_pkg;
  // Register byte offsets
  localparam logic [7:0] lna_control_reg_off = 8'h00;
  localparam logic [7:0] strength_threshold_reg_off = 8'h04;
  localparam logic [7:0] rx_config_reg_off = 8'h08;
  localparam logic [7:0] filter_bandwidth_reg_off = 8'h0C;
  localparam logic [7:0] digital_gain_test_reg_off = 8'h10;
  localparam logic [7:0] gain_threshold_reg_off = 8'h14;
  localparam logic [7:0] gain_threshold_hi_reg_off = 8'h18;
  localparam logic [7:0] status_reg_off = 8'h1C;
  localparam logic [7:0] reference_reg_off = 8'h20;
  // lna_control_reg fields
  localparam int zin_bit = 7;
  localparam int readback_lsb = 3;
  localparam int select_lsb = 0;
  // rx_config_reg fields
  localparam int rx_enable_bit = 0;
  localparam int continuous_bit = 1;
  localparam int auto_restart_bit = 2;
  localparam int restart_bit = 3;
  localparam int afc_enable_bit = 4;
  localparam int ook_bit = 5;
  localparam int delay_lsb = 8;
  // filter_bandwidth_reg fields
  localparam int exp_lsb = 0;
  localparam int mant_lsb = 3;
  localparam int afc_exp_lsb = 8;
  localparam int afc_mant_lsb = 11;
  // Reset values
  localparam logic [7:0] lna_reset = 8'h00;
  localparam logic [7:0] threshold_reset = 8'hE4;
  localparam logic [15:0] rx_config_reset = 16'h0000;
  localparam logic [15:0] bandwidth_reset = 16'h0B55;
  localparam logic [7:0] tracker_reset = 8'h30;
  localparam logic [7:0] tracker_low_index = 8'h10;
  // Gain codes
  localparam logic [2:0] gain_auto = 3'h0;
  localparam logic [2:0] gain_max = 3'h1;
  localparam logic [2:0] gain_min = 3'h6;
  localparam logic [2:0] gain_reserved = 3'h7;
  // Gain reference terms in dB / dBm
  localparam int thermal_floor_dbm = -174;
  localparam int noise_figure_db = 7;
  localparam int demodulator_snr = 8;
  localparam int fade_allowance = 5;
  // WAIT exit sample count
  localparam int wait_samples = 2;
  // Interpacket delay unit in microseconds and cycles at 125 MHz
  localparam int delay_unit_us = 1;
  localparam int clock_mhz = 125;
  localparam int delay_unit_cycles = delay_unit_us * clock_mhz;
  // Digital gain interval in bit periods
  localparam int tracker_bits = 2;
  localparam int fir_taps = 16;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_hold = 2'b11,
    st_delay = 2'b10
  } agc_state_type;
endpackage : rx_gain_pkg

// ### src/channel_filter.sv
// Channel path: decimates one-bit converter streams and runs a moving FIR.
// Assumes sample_en marks each converter bit and dec_en each decimated sample.
module channel_filter
  import rx_gain_pkg::*;
#(
  parameter int taps = fir_taps,
  parameter int width = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stream in
  input wire logic sample_en,
  input wire logic dec_en,
  input wire logic adc_bit,
  input wire logic [3:0] digital_gain,
  // Filtered out
  output logic [width-1:0] filtered
);
  initial begin
    if (taps < 2 || taps > 64 || width < 8) $error("channel_filter parameters unsupported");
  end

  logic [width-1:0] accum;
  logic [width-1:0] line [taps];
  logic [width+5:0] sum;

  // Decimation by bit counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum <= '0;
    end else if (dec_en) begin
      accum <= {{(width-1){1'b0}}, adc_bit & sample_en};
    end else if (sample_en && adc_bit) begin
      accum <= accum + 1'b1;
    end
  end

  // Tap line of decimated samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < taps; i++) line[i] <= '0;
    end else if (dec_en) begin
      line[0] <= accum;
      for (int i = 1; i < taps; i++) line[i] <= line[i-1];
    end
  end

  always_comb begin
    sum = '0;
    for (int i = 0; i < taps; i++) sum = sum + {6'h00, line[i]};
  end

  // Averaged output with digital gain shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filtered <= '0;
    end else if (dec_en) begin
      filtered <= width'((sum >> $clog2(taps)) << digital_gain);
    end
  end
endmodule : channel_filter

// ### src/rx_gain_control.sv
// Receiver gain control: AGC loop, manual gain, reference level, digital gain, filters.
// Assumes APB master on pclk; strength samples and FIFO state come from the receiver.
// Operation
// - Code 000 selects automatic gain loop
// - Codes 001-110 fixed gains, 111 reserved
// - WAIT until two consecutive samples exceed threshold
// - Pick one gain step, hold for packet
// - Applied gain readable in lna_control_reg
// - Packet mode, no auto restart: keep gain
// - Auto restart: FIFO empty, delay, then WAIT
// - Restart trigger returns to WAIT unless receiver disabled
// - Continuous mode keeps gain until restart
// - AFC startup uses AFC filter bandwidth
// - Reference is -174+NF+SNR+10log(2BW)+margin
// - Digital gain readjusts every two bits
// - Digital gain works in all modes
// - Channel filter is 16-tap FIR
// - One-bit I/Q streams decimated and filtered
// - Impedance select picks 50 or 200 Ohms
// - Bandwidth = fxosc/(mant*2^(exp+2 or 3))
// - Mantissa 00/01/10 means 16/20/24
//
// Local design decisions: the register offsets and register access over APB.
module rx_gain_control
  import rx_gain_pkg::*;
#(
  parameter int xosc_khz = 32000,
  parameter int width = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver status
  input wire logic strength_valid,
  input wire logic [7:0] signal_strength_value,
  input wire logic fifo_empty,
  input wire logic packet_done,
  input wire logic afc_running,
  input wire logic bit_tick,
  input wire logic sample_en,
  input wire logic dec_en,
  input wire logic adc_i,
  input wire logic adc_q,
  // Front-end control
  output logic [2:0] lna_gain_step,
  output logic impedance_200,
  output logic [7:0] filter_mant_exp,
  output logic [31:0] bandwidth_hz,
  output logic [3:0] digital_gain,
  output logic [width-1:0] filtered_i,
  output logic [width-1:0] filtered_q,
  output logic agc_waiting
);
  initial begin
    if (xosc_khz < 1000 || width < 8) $error("rx_gain_control parameters unsupported");
  end

  logic [7:0] lna_ctrl;
  logic [7:0] strength_threshold;
  logic [15:0] rx_config;
  logic [15:0] bandwidth_cfg;
  logic [7:0] tracker_cfg;
  logic [31:0] gain_thresholds;
  logic [7:0] gain_threshold_five;
  agc_state_type state;
  logic [1:0] pass_count;
  logic [2:0] auto_step;
  logic [7:0] delay_count;
  logic [7:0] unit_count;
  logic [7:0] bit_count;
  logic [7:0] peak;
  logic restart_pulse;
  logic [15:0] reference_dbm;

  wire logic wr_access = psel && penable && pwrite;
  wire logic rx_enable = rx_config[rx_enable_bit];
  wire logic continuous = rx_config[continuous_bit];
  wire logic auto_restart = rx_config[auto_restart_bit];
  wire logic ook = rx_config[ook_bit];
  wire logic [7:0] interpacket_receive_delay = rx_config[delay_lsb +: 8];
  wire logic tracker_on = (tracker_cfg == tracker_reset) || (tracker_cfg == tracker_low_index);

  function automatic logic [4:0] mant_value(input logic [1:0] code);
    case (code)
      2'b00: mant_value = 5'd16;
      2'b01: mant_value = 5'd20;
      default: mant_value = 5'd24;
    endcase
  endfunction

  function automatic logic [31:0] bw_hz(input logic [4:0] mant, input logic [2:0] ex,
                                        input logic ook_mode);
    logic [31:0] div;
    div = {27'h0, mant} << ({29'h0, ex} + 32'd2 + {31'h0, ook_mode});
    bw_hz = (32'(xosc_khz) * 32'd1000) / div;
  endfunction

  function automatic logic [7:0] log10x10(input logic [31:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 32; i++) if (v[i]) r = 8'((i * 301 + 50) / 100);
    log10x10 = r;
  endfunction

  // APB handshake: zero wait state
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lna_ctrl <= lna_reset;
      strength_threshold <= threshold_reset;
      rx_config <= rx_config_reset;
      bandwidth_cfg <= bandwidth_reset;
      tracker_cfg <= tracker_reset;
      gain_thresholds <= 32'h5A_4B_3C_2D;
      gain_threshold_five <= 8'h69;
    end else if (wr_access) begin
      if (paddr == lna_control_reg_off) begin
        lna_ctrl <= {pwdata[zin_bit], 4'h0, pwdata[select_lsb +: 3]};
      end else if (paddr == strength_threshold_reg_off) begin
        strength_threshold <= pwdata[7:0];
      end else if (paddr == rx_config_reg_off) begin
        rx_config <= {pwdata[15:8], 2'h0, pwdata[ook_bit], pwdata[afc_enable_bit],
                      1'h0, pwdata[2:0]};
      end else if (paddr == filter_bandwidth_reg_off) begin
        bandwidth_cfg <= pwdata[15:0];
      end else if (paddr == digital_gain_test_reg_off) begin
        tracker_cfg <= pwdata[7:0];
      end else if (paddr == gain_threshold_reg_off) begin
        gain_thresholds <= pwdata;
      end else if (paddr == gain_threshold_hi_reg_off) begin
        gain_threshold_five <= pwdata[7:0];
      end
    end
  end

  // Restart trigger is self-clearing
  assign restart_pulse = wr_access && (paddr == rx_config_reg_off) && pwdata[restart_bit];

  // Gain loop state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      pass_count <= 2'h0;
      auto_step <= gain_max;
      delay_count <= 8'h00;
      unit_count <= 8'h00;
    end else if (!rx_enable) begin
      state <= st_idle;
      pass_count <= 2'h0;
    end else if (restart_pulse) begin
      state <= st_wait;
      pass_count <= 2'h0;
    end else begin
      case (state)
        st_idle: begin
          state <= st_wait;
          pass_count <= 2'h0;
        end
        st_wait: begin
          if (strength_valid) begin
            if (signal_strength_value > strength_threshold) begin
              if (pass_count == 2'(wait_samples - 1)) begin
                state <= st_hold;
                auto_step <= 3'(gain_max + (signal_strength_value > gain_thresholds[7:0])
                  + (signal_strength_value > gain_thresholds[15:8])
                  + (signal_strength_value > gain_thresholds[23:16])
                  + (signal_strength_value > gain_thresholds[31:24])
                  + (signal_strength_value > gain_threshold_five));
              end else begin
                pass_count <= pass_count + 2'h1;
              end
            end else begin
              pass_count <= 2'h0;
            end
          end
        end
        st_hold: begin
          // Gain held; continuous mode or no auto restart stays here
          if (!continuous && auto_restart && packet_done) begin
            state <= st_delay;
            delay_count <= interpacket_receive_delay;
            unit_count <= 8'(delay_unit_cycles - 1);
          end
        end
        st_delay: begin
          if (fifo_empty) begin
            if (delay_count == 8'h00) begin
              state <= st_wait;
              pass_count <= 2'h0;
            end else if (unit_count == 8'h00) begin
              delay_count <= delay_count - 8'h01;
              unit_count <= 8'(delay_unit_cycles - 1);
            end else begin
              unit_count <= unit_count - 8'h01;
            end
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // Applied gain: manual code or loop result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lna_gain_step <= gain_max;
    end else if (lna_ctrl[2:0] == gain_auto) begin
      if (state == st_hold) lna_gain_step <= auto_step;
      else lna_gain_step <= gain_max;
    end else if (lna_ctrl[2:0] != gain_reserved) begin
      lna_gain_step <= lna_ctrl[2:0];
    end
  end

  assign impedance_200 = lna_ctrl[zin_bit];
  assign agc_waiting = (state == st_wait);

  // Filter setting: AFC bandwidth during startup correction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_mant_exp <= bandwidth_reset[7:0];
      bandwidth_hz <= '0;
    end else if (rx_config[afc_enable_bit] && afc_running) begin
      filter_mant_exp <= bandwidth_cfg[15:8];
      bandwidth_hz <= bw_hz(mant_value(bandwidth_cfg[afc_mant_lsb +: 2]),
                            bandwidth_cfg[afc_exp_lsb +: 3], ook);
    end else begin
      filter_mant_exp <= bandwidth_cfg[7:0];
      bandwidth_hz <= bw_hz(mant_value(bandwidth_cfg[mant_lsb +: 2]),
                            bandwidth_cfg[exp_lsb +: 3], ook);
    end
  end

  // Reference level in dBm, two's complement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_dbm <= '0;
    end else begin
      reference_dbm <= 16'(thermal_floor_dbm + noise_figure_db + demodulator_snr
                       + fade_allowance) + {8'h00, log10x10({bandwidth_hz[30:0], 1'b0})};
    end
  end

  // Digital gain tracker, every two bit periods in any mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_count <= 8'h00;
      peak <= 8'h00;
      digital_gain <= 4'h0;
    end else if (tracker_on && bit_tick) begin
      if (bit_count == 8'(tracker_bits - 1)) begin
        bit_count <= 8'h00;
        peak <= 8'h00;
        digital_gain <= (peak > 8'hC0) ? 4'h0 : (peak > 8'h80) ? 4'h1 :
                        (peak > 8'h40) ? 4'h2 : 4'h3;
      end else begin
        bit_count <= bit_count + 8'h01;
        if (signal_strength_value > peak) peak <= signal_strength_value;
      end
    end else if (!tracker_on) begin
      digital_gain <= 4'h0;
    end
  end

  // I and Q channel filters
  channel_filter #(.taps(fir_taps), .width(width)) filter_i (
    .pclk(pclk), .presetn(presetn), .sample_en(sample_en), .dec_en(dec_en),
    .adc_bit(adc_i), .digital_gain(digital_gain), .filtered(filtered_i));
  channel_filter #(.taps(fir_taps), .width(width)) filter_q (
    .pclk(pclk), .presetn(presetn), .sample_en(sample_en), .dec_en(dec_en),
    .adc_bit(adc_q), .digital_gain(digital_gain), .filtered(filtered_q));

  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == lna_control_reg_off) begin
      prdata = {24'h0, lna_ctrl[zin_bit], 1'b0, lna_gain_step, lna_ctrl[2:0]};
    end else if (paddr == strength_threshold_reg_off) begin
      prdata = {24'h0, strength_threshold};
    end else if (paddr == rx_config_reg_off) begin
      prdata = {16'h0, rx_config};
    end else if (paddr == filter_bandwidth_reg_off) begin
      prdata = {16'h0, bandwidth_cfg};
    end else if (paddr == digital_gain_test_reg_off) begin
      prdata = {24'h0, tracker_cfg};
    end else if (paddr == gain_threshold_reg_off) begin
      prdata = gain_thresholds;
    end else if (paddr == gain_threshold_hi_reg_off) begin
      prdata = {24'h0, gain_threshold_five};
    end else if (paddr == status_reg_off) begin
      prdata = {20'h0, digital_gain, 4'h0, pass_count, state};
    end else if (paddr == reference_reg_off) begin
      prdata = {16'h0, reference_dbm};
    end
  end
endmodule : rx_gain_control

// ### testbench/rf_signal_model.sv
// Partner: received signal as seen through the receiver front end.
// Assumes one pclk domain; a strength sample every 8 cycles.
module rf_signal_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level set by the bench
  input wire logic [7:0] level,
  // Receiver stream
  output logic strength_valid,
  output logic [7:0] signal_strength_value,
  output logic bit_tick,
  output logic sample_en,
  output logic dec_en,
  output logic adc_i,
  output logic adc_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  logic [31:0] r;
  int seed = 32'h5f775759;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 5'h00;
      strength_valid <= 1'b0;
      signal_strength_value <= 8'h00;
      bit_tick <= 1'b0;
      sample_en <= 1'b0;
      dec_en <= 1'b0;
      adc_i <= 1'b0;
      adc_q <= 1'b0;
    end else begin
      r = $random(seed);
      cnt <= cnt + 5'h01;
      strength_valid <= cnt[2:0] == 3'h7;
      signal_strength_value <= cnt[2:0] == 3'h7 ? level : ~level;
      bit_tick <= cnt == 5'h1F;
      sample_en <= 1'b1;
      dec_en <= cnt[1:0] == 2'h3;
      adc_i <= r[0];
      adc_q <= r[1];
    end
  end
endmodule : rf_signal_model

// ### testbench/rx_gain_checker.sv
// Checker: concurrent assertions on the rx_gain_control ports.
// Assumes a bind into the design top; one pclk domain.
module rx_gain_checker
  import rx_gain_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Front end
  input wire logic [2:0] lna_gain_step,
  input wire logic impedance_200,
  input wire logic [31:0] bandwidth_hz,
  input wire logic [3:0] digital_gain,
  input wire logic agc_waiting
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr;
  assign wr = psel && penable && pwrite;
  chk_zero_wait: assert property (psel && penable |-> pready && !pslverr)
    else $error("access not answered at once");
  chk_manual_code: assert property (
    wr && paddr == 8'h00 && pwdata[2:0] inside {[3'h1:3'h6]}
    |=> ##1 lna_gain_step == $past(pwdata[2:0], 2)) else $error("manual gain not applied");
  chk_impedance_bit: assert property (
    wr && paddr == 8'h00 |=> ##1 impedance_200 == $past(pwdata[7], 2))
    else $error("impedance select not applied");
  chk_step_range: assert property (lna_gain_step inside {[3'h1:3'h6]})
    else $error("gain step out of range");
  chk_unmapped_zero: assert property (
    psel && penable && !pwrite && paddr > 8'h20 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_restart_wait: assert property (
    wr && paddr == 8'h08 && pwdata[3] && pwdata[0] |=> ##[0:2] agc_waiting)
    else $error("restart did not reach wait");
  chk_digital_range: assert property (digital_gain <= 4'h3)
    else $error("digital gain out of range");
  chk_bw_valid: assert property ($past(presetn) |-> bandwidth_hz != 32'h0)
    else $error("bandwidth not computed");
  chk_reset_step: assert property ($rose(presetn) |-> lna_gain_step == 3'h1 && !agc_waiting)
    else $error("wrong state after reset");
endmodule : rx_gain_checker

// ### testbench/tb_rx_gain_control.sv
// Testbench: APB host and receiver stimulus for rx_gain_control.
// Assumes rf_signal_model drives strength samples and converter streams.
module tb_rx_gain_control
  import rx_gain_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, level = 8'h10;
  logic [31:0] pwdata = 32'h0, prdata, bandwidth_hz;
  logic pready, pslverr, strength_valid, bit_tick, sample_en, dec_en, adc_i, adc_q;
  logic fifo_empty = 1'b0, packet_done = 1'b0, afc_running = 1'b0;
  logic [7:0] signal_strength_value, filter_mant_exp;
  logic [2:0] lna_gain_step;
  logic [3:0] digital_gain;
  logic [11:0] filtered_i, filtered_q;
  logic impedance_200, agc_waiting;
  logic [63:0] q [$];
  logic [63:0] note;
  logic [7:0] ra [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24};
  logic [31:0] rv [7] = '{32'hE4, 32'h0, 32'h0B55, 32'h30, 32'h5A4B3C2D, 32'h69, 32'h0};
  logic [7:0] lv [6] = '{8'h21, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70};
  logic [2:0] s;
  int n_mismatch = 0, comparisons = 0;
  always #4 pclk = ~pclk;
  rx_gain_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strength_valid(strength_valid),
    .signal_strength_value(signal_strength_value), .fifo_empty(fifo_empty),
    .packet_done(packet_done), .afc_running(afc_running), .bit_tick(bit_tick),
    .sample_en(sample_en), .dec_en(dec_en), .adc_i(adc_i), .adc_q(adc_q),
    .lna_gain_step(lna_gain_step), .impedance_200(impedance_200),
    .filter_mant_exp(filter_mant_exp), .bandwidth_hz(bandwidth_hz),
    .digital_gain(digital_gain), .filtered_i(filtered_i), .filtered_q(filtered_q),
    .agc_waiting(agc_waiting));
  rf_signal_model i_rf (.pclk(pclk), .presetn(presetn), .level(level),
    .strength_valid(strength_valid), .signal_strength_value(signal_strength_value),
    .bit_tick(bit_tick), .sample_en(sample_en), .dec_en(dec_en), .adc_i(adc_i),
    .adc_q(adc_q));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task report_and_stop;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic give_up;
    n_mismatch++;
    report_and_stop();
  endtask : give_up
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) give_up();
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    q.push_back({m, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    while (agc_waiting !== v && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) give_up();
  endtask : wait_flag
  task automatic pulse_done;
    @(posedge pclk);
    packet_done <= 1'b1;
    @(posedge pclk);
    packet_done <= 1'b0;
    repeat (40) @(posedge pclk);
  endtask : pulse_done
  task automatic search(input logic [7:0] l, input logic [2:0] st);
    level <= l;
    wr(8'h08, 32'h9);
    wait_flag(1'b1);
    wait_flag(1'b0);
    repeat (2) @(posedge pclk);
    check({29'h0, lna_gain_step}, {29'h0, st});
    rd(8'h00, 32'h38, {26'h0, st, 3'h0});
  endtask : search
  // Read results are compared in the order they were noted
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      note = q.pop_front();
      check(prdata & note[63:32], note[31:0]);
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ra[i], 32'hFFFFFFFF, rv[i]);
    rd(8'h20, 32'hFFF0, 32'hFF90);
    check({24'h0, filter_mant_exp}, 32'h55);
    check(bandwidth_hz, 32'd10416);
    $display("reset test done");
    for (int c = 1; c < 8; c++) begin
      wr(8'h00, {24'h0, c[0], 4'h0, 3'(c)});
      repeat (2) @(posedge pclk);
      s = c == 7 ? 3'h6 : 3'(c);
      check({29'h0, lna_gain_step}, {29'h0, s});
      check({31'h0, impedance_200}, {31'h0, c[0]});
      rd(8'h00, 32'hBF, {24'h0, c[0], 1'b0, s, 3'(c)});
    end
    $display("manual gain test done");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h20);
    wr(8'h08, 32'h1);
    wait_flag(1'b1);
    repeat (12) begin
      repeat (8) @(posedge pclk);
      level <= level ^ 8'h60;
    end
    check({31'h0, agc_waiting}, 32'h1);
    rd(8'h1C, 32'h3, 32'h1);
    for (int k = 0; k < 6; k++) search(lv[k], 3'(k + 1));
    $display("gain search test done");
    level <= 8'h21;
    pulse_done();
    check({29'h0, lna_gain_step}, 32'h6);
    rd(8'h1C, 32'h3, 32'h3);
    wr(8'h08, 32'h7);
    pulse_done();
    check({29'h0, lna_gain_step}, 32'h6);
    level <= 8'h50;
    wr(8'h08, 32'h105);
    pulse_done();
    repeat (260) @(posedge pclk);
    rd(8'h1C, 32'h3, 32'h2);
    fifo_empty <= 1'b1;
    repeat (100) @(posedge pclk);
    rd(8'h1C, 32'h3, 32'h2);
    wait_flag(1'b1);
    wait_flag(1'b0);
    repeat (2) @(posedge pclk);
    check({29'h0, lna_gain_step}, 32'h4);
    $display("hold and restart test done");
    for (int m = 0; m < 3; m++) begin
      for (int e = 0; e < 8; e += 7) begin
        wr(8'h0C, {19'h0, 5'h0B, 3'h0, 2'(m), 3'(e)});
        repeat (3) @(posedge pclk);
        check(bandwidth_hz, 32000000 / ((16 + 4 * m) << (e + 2)));
        check({24'h0, filter_mant_exp}, {27'h0, 2'(m), 3'(e)});
      end
    end
    wr(8'h08, 32'h21);
    repeat (3) @(posedge pclk);
    check(bandwidth_hz, 32'd1302);
    wr(8'h08, 32'h11);
    afc_running <= 1'b1;
    repeat (3) @(posedge pclk);
    check({24'h0, filter_mant_exp}, 32'h0B);
    check(bandwidth_hz, 32'd50000);
    afc_running <= 1'b0;
    $display("bandwidth test done");
    wr(8'h10, 32'h10);
    rd(8'h10, 32'hFF, 32'h10);
    repeat (300) @(posedge pclk);
    rd(8'h1C, 32'hF00, 32'h200);
    check({31'h0, filtered_i != 12'h000 && filtered_i <= 12'h010}, 32'h1);
    check({31'h0, filtered_q != 12'h000 && filtered_q <= 12'h010}, 32'h1);
    wr(8'h10, 32'h0);
    rd(8'h1C, 32'hF00, 32'h0);
    $display("digital gain test done");
    report_and_stop();
  end
endmodule : tb_rx_gain_control
bind rx_gain_control rx_gain_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .lna_gain_step(lna_gain_step),
  .impedance_200(impedance_200), .bandwidth_hz(bandwidth_hz),
  .digital_gain(digital_gain), .agc_waiting(agc_waiting));
